// ---- efr_pkg.sv ----
package efr_pkg;

   // Register offsets on the 8-bit register port.
   localparam logic [7:0] EFR_ADDR_IDENTITY = 8'h10;
   localparam logic [7:0] EFR_ADDR_RESYNC   = 8'h12;
   localparam logic [7:0] EFR_ADDR_STATUS   = 8'h16;
   localparam logic [7:0] EFR_ADDR_MASK     = 8'h17;
   localparam logic [7:0] EFR_ADDR_SEARCH   = 8'h1c;

   // Reset values of the writable and latched registers.
   localparam logic [7:0] EFR_MASK_RESET    = 8'h00;
   localparam logic [7:0] EFR_RD_RESET      = 8'h00;

   // Field positions in the resync-criteria register.
   localparam int EFR_EVT_CAS = 0;
   localparam int EFR_EVT_FAS = 1;
   localparam int EFR_EVT_CRC = 2;

   // Resync criteria counts.
   localparam logic [1:0] EFR_CAS_ERR_RUN   = 2'd2;
   localparam logic [1:0] EFR_FAS_ERR_RUN   = 2'd3;
   localparam logic [9:0] EFR_CRC_BLOCK     = 10'd1000;
   localparam logic [9:0] EFR_CRC_ERR_LIMIT = 10'd915;

   // Alarm criteria counts.
   localparam logic [1:0]  EFR_RA_RUN       = 2'd3;
   localparam logic [8:0]  EFR_UA_LAST_BIT  = 9'd511;
   localparam logic [1:0]  EFR_UA_ZEROS     = 2'd3;
   localparam logic [11:0] EFR_LOS_E1_SHORT = 12'd255;
   localparam logic [11:0] EFR_LOS_E1_LONG  = 12'd2048;
   localparam logic [11:0] EFR_LOS_T1_ZEROS = 12'd192;
   localparam logic [7:0]  EFR_LOS_E1_WIN   = 8'd255;
   localparam logic [5:0]  EFR_LOS_E1_ONES  = 6'd32;
   localparam logic [7:0]  EFR_LOS_T1_WIN   = 8'd112;
   localparam logic [5:0]  EFR_LOS_T1_ONES  = 6'd14;

endpackage

// ---- efr_los_detect.sv ----
`timescale 1ns/1ps
// Counts consecutive zeros to raise loss of signal, then looks for enough
// ones inside a window of bit times to drop it again.
module efr_los_detect
   import efr_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        bit_en,
   input  wire logic        bit_val,
   input  wire logic [11:0] zero_limit,
   input  wire logic [7:0]  window_len,
   input  wire logic [5:0]  ones_need,
   output logic             los_r
);

   typedef struct packed {
      logic [11:0] zeros;
      logic [7:0]  win;
      logic [5:0]  ones;
      logic        los;
   } efr_los_type;

   efr_los_type st_r;
   efr_los_type st_nxt;

   // The zero run stops one below the limit, where loss is raised, so a long outage cannot wrap it.
   always_comb begin
      st_nxt = st_r;
      if (bit_en) begin
         if (!st_r.los) begin
            if (bit_val) begin
               st_nxt.zeros = 12'd0;
            end else if (st_r.zeros + 12'd1 >= zero_limit) begin
               st_nxt.los   = 1'b1;
               st_nxt.win   = 8'd0;
               st_nxt.ones  = 6'd0;
            end else begin
               st_nxt.zeros = st_r.zeros + 12'd1;
            end
         end else begin
            st_nxt.ones = st_r.ones + {5'd0, bit_val};
            st_nxt.win  = st_r.win + 8'd1;
            if (st_r.ones + {5'd0, bit_val} >= ones_need) begin
               st_nxt.los   = 1'b0;
               st_nxt.zeros = 12'd0;
            end else if (st_r.win + 8'd1 >= window_len) begin
               st_nxt.win   = 8'd0;
               st_nxt.ones  = 6'd0;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign los_r = st_r.los;

endmodule

// ---- efr_status_alarms.sv ----
`timescale 1ns/1ps
// How it works
// - Si bits come from serial input at select 0, internal registers at 1.
// - Pass-through 0 sources FAS, Sa and remote alarm internally; 1 from serial.
// - Two CAS multiframe words in error in a row set the CAS event.
// - Three frame alignment words in error in a row set the FAS event.
// - 915 or more bad CRC4 codewords out of 1000 set the CRC event.
// - Three search bits read 1 only while the synchronizer searches.
// - Sync counter counts search timeouts, wraps, clears on sync or CRC4 off.
// - Counter is six bits; bits 0,2,3,4,5 readable at register bits 3..7.
// - Frame loss holds from reset to sync, and on resync or manual resync.
// - E1 signal loss after 255 or 2048 zeros; clears on 32 ones in 255.
// - Remote alarm follows three equal non-align bit 3 values in a row.
// - Unframed ones when under three zeros in 512 bits; clears otherwise.
// - Multiframe remote alarm when slot 16 bit 6 set in two multiframes.
// - V5.2 link when two of the last three Sa7 bits are zero.
// - Identity register gives device code high and revision low.
// - Frame loss status bit is set while the receiver is not synchronized.
// - T1 signal loss after 192 zeros; 6312 kHz mode out-of-range sets the status bit only, not signal_loss_cond_r.
// - AIS bit follows unframed ones; yellow bit follows yellow in T1 only.
// - Clear-event bits latch when conditions end and stay until read.
// - Condition mask bits enable interrupts on rising edges only.
// - Clear-event mask bits enable interrupts when the event sets.
// - In E1 mode, criteria select 0 means 255 zeros, 1 means 2048 zeros.
module efr_status_alarms
   import efr_pkg::*;
#(
   parameter logic [3:0] DEVICE_CODE = 4'h5, // Arbitrary value.
   parameter logic [3:0] REVISION    = 4'h1  // Arbitrary value.
)
(
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic [7:0] addr,
   input  wire logic       rd_en,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data_r,
   output logic            irq_r,
   input  wire logic       rx_bit_en,
   input  wire logic       rx_bit,
   input  wire logic       t1_mode,
   input  wire logic       sync6312_mode,
   input  wire logic       sync6312_out_of_range,
   input  wire logic       signal_loss_criteria_select,
   input  wire logic       resync_request,
   input  wire logic       frame_sync_achieved,
   input  wire logic       fas_word_strobe,
   input  wire logic       fas_word_error,
   input  wire logic       cas_word_strobe,
   input  wire logic       cas_word_error,
   input  wire logic       crc_word_strobe,
   input  wire logic       crc_word_error,
   input  wire logic       crc_search_timeout,
   input  wire logic       crc_sync_ok,
   input  wire logic       crc4_enable,
   input  wire logic       crc_mf_search_active,
   input  wire logic       cas_mf_search_active,
   input  wire logic       frame_align_search_active,
   input  wire logic       nfas_strobe,
   input  wire logic       nfas_bit3,
   input  wire logic       mf_strobe,
   input  wire logic       ts16_f0_bit6,
   input  wire logic       sa7_strobe,
   input  wire logic       sa7_bit,
   input  wire logic       t1_yellow_detect,
   input  wire logic       tx_bit_en,
   input  wire logic       tx_is_si_bit,
   input  wire logic       tx_internal_bit,
   input  wire logic       serial_tx_data_in,
   input  wire logic       intl_bit_source_select,
   input  wire logic       slot0_passthrough,
   output logic            tx_ts0_bit_r,
   output logic            source_conflict_r,
   output logic            frame_loss_cond_r,
   output logic            signal_loss_cond_r,
   output logic            all_ones_cond_r,
   output logic            remote_alarm_cond_r,
   output logic            multiframe_remote_alarm_r,
   output logic            v5_link_detect_r
);

   typedef struct packed {
      logic [7:0] rd_data;
      logic       irq;
      logic       tx_bit;
      logic       conflict;
      logic       lof;
      logic [3:0] cond_prev;
      logic [3:0] cond_evt;
      logic [3:0] clr_evt;
      logic [2:0] resync;
      logic [5:0] csc;
      logic [7:0] mask;
      logic [1:0] fas_run;
      logic [1:0] cas_run;
      logic [9:0] crc_words;
      logic [9:0] crc_errs;
      logic [1:0] ra_run;
      logic       ra;
      logic [8:0] ua_win;
      logic [1:0] ua_zeros;
      logic       ua;
      logic       mf_prev;
      logic       mfra;
      logic [2:0] sa7_hist;
      logic       v5;
   } efr_state_type;

   efr_state_type st_r;
   efr_state_type st_nxt;
   logic          los_line;
   logic [11:0]   los_limit;
   logic [7:0]    los_window;
   logic [5:0]    los_ones;
   logic          los_cond;
   logic          yel_cond;
   logic [3:0]    cond;
   logic          rd_status;
   logic          rd_resync;

   // Majority-of-three zeros check for the Sa7 history.
   function automatic logic two_of_three_zero(input logic [2:0] h);
      two_of_three_zero = (!h[0] & !h[1]) | (!h[0] & !h[2]) | (!h[1] & !h[2]);
   endfunction

   // Zero-run and recovery figures depend on the line mode.
   always_comb begin
      if (t1_mode) begin
         los_limit  = EFR_LOS_T1_ZEROS;
         los_window = EFR_LOS_T1_WIN;
         los_ones   = EFR_LOS_T1_ONES;
      end else begin
         los_limit  = signal_loss_criteria_select ? EFR_LOS_E1_LONG
                                                  : EFR_LOS_E1_SHORT;
         los_window = EFR_LOS_E1_WIN;
         los_ones   = EFR_LOS_E1_ONES;
      end
   end

   efr_los_detect u_los (
      .clock      (clock),
      .rst_b      (rst_b),
      .bit_en     (rx_bit_en),
      .bit_val    (rx_bit),
      .zero_limit (los_limit),
      .window_len (los_window),
      .ones_need  (los_ones),
      .los_r      (los_line)
   );

   // Live condition vector in status bit order.
   assign los_cond  = los_line | (sync6312_mode & sync6312_out_of_range);
   assign yel_cond  = t1_mode & t1_yellow_detect;
   assign cond      = {yel_cond, st_r.ua, los_cond, st_r.lof};
   assign rd_status = rd_en & (addr == EFR_ADDR_STATUS);
   assign rd_resync = rd_en & (addr == EFR_ADDR_RESYNC);

   // One pass computes every counter, flag and register except the signal-loss detector's for the next edge.
   always_comb begin
      logic [2:0] rs_set;
      logic [7:0] pend;
      rs_set = 3'b000;
      pend   = 8'h00;
      st_nxt = st_r;

      // Resync criteria counters.
      if (cas_word_strobe) begin
         st_nxt.cas_run = cas_word_error ? st_r.cas_run + 2'd1 : 2'd0;
         if (cas_word_error && st_r.cas_run + 2'd1 == EFR_CAS_ERR_RUN) begin
            rs_set[EFR_EVT_CAS] = 1'b1;
            st_nxt.cas_run = 2'd0;
         end
      end
      if (fas_word_strobe) begin
         st_nxt.fas_run = fas_word_error ? st_r.fas_run + 2'd1 : 2'd0;
         if (fas_word_error && st_r.fas_run + 2'd1 == EFR_FAS_ERR_RUN) begin
            rs_set[EFR_EVT_FAS] = 1'b1;
            st_nxt.fas_run = 2'd0;
         end
      end
      if (crc_word_strobe) begin
         st_nxt.crc_words = st_r.crc_words + 10'd1;
         st_nxt.crc_errs  = st_r.crc_errs + {9'd0, crc_word_error};
         if (st_r.crc_words + 10'd1 == EFR_CRC_BLOCK) begin
            if (st_r.crc_errs + {9'd0, crc_word_error} >= EFR_CRC_ERR_LIMIT) begin
               rs_set[EFR_EVT_CRC] = 1'b1;
            end
            st_nxt.crc_words = 10'd0;
            st_nxt.crc_errs  = 10'd0;
         end
      end

      // A new event wins over the clear that a read of the register makes.
      st_nxt.resync = (rd_resync ? 3'b000 : st_r.resync) | rs_set;

      // Frame loss sets on any resync cause and beats a same-cycle sync.
      if (|rs_set || resync_request) begin
         st_nxt.lof = 1'b1;
      end else if (frame_sync_achieved) begin
         st_nxt.lof = 1'b0;
      end

      // Search-timeout counter, six bits, rolls over by width.
      if (crc_sync_ok || !crc4_enable) begin
         st_nxt.csc = 6'd0;
      end else if (crc_search_timeout) begin
         st_nxt.csc = st_r.csc + 6'd1;
      end

      // Remote alarm needs three equal opposite values to change state.
      if (nfas_strobe) begin
         if (nfas_bit3 == st_r.ra) begin
            st_nxt.ra_run = 2'd0;
         end else if (st_r.ra_run + 2'd1 == EFR_RA_RUN) begin
            st_nxt.ra     = nfas_bit3;
            st_nxt.ra_run = 2'd0;
         end else begin
            st_nxt.ra_run = st_r.ra_run + 2'd1;
         end
      end

      // Zero count saturates at three over each 512-bit span.
      if (rx_bit_en) begin
         st_nxt.ua_win = st_r.ua_win + 9'd1;
         if (!rx_bit && st_r.ua_zeros != EFR_UA_ZEROS) begin
            st_nxt.ua_zeros = st_r.ua_zeros + 2'd1;
         end
         if (st_r.ua_win == EFR_UA_LAST_BIT) begin
            st_nxt.ua       = (st_nxt.ua_zeros != EFR_UA_ZEROS);
            st_nxt.ua_zeros = 2'd0;
         end
      end

      // Multiframe remote alarm compares this multiframe with the last.
      if (mf_strobe) begin
         st_nxt.mf_prev = ts16_f0_bit6;
         st_nxt.mfra    = ts16_f0_bit6 & st_r.mf_prev;
      end
      if (sa7_strobe) begin
         st_nxt.sa7_hist = {st_r.sa7_hist[1:0], sa7_bit};
         st_nxt.v5       = two_of_three_zero({st_r.sa7_hist[1:0], sa7_bit});
      end

      // Edge latches; a read clears them but a same-cycle edge survives.
      st_nxt.cond_prev = cond;
      st_nxt.cond_evt  = (rd_status ? 4'h0 : st_r.cond_evt) | (cond & ~st_r.cond_prev);
      st_nxt.clr_evt   = (rd_status ? 4'h0 : st_r.clr_evt) | (st_r.cond_prev & ~cond);

      if (wr_en && addr == EFR_ADDR_MASK) begin
         st_nxt.mask = wr_data;
      end
      pend = {st_nxt.clr_evt, st_nxt.cond_evt} & st_nxt.mask;
      st_nxt.irq = |pend;

      // Read data are captured before this cycle's clear-on-read takes hold.
      if (rd_en) begin
         case (addr)
            EFR_ADDR_IDENTITY: st_nxt.rd_data = {DEVICE_CODE, REVISION};
            EFR_ADDR_RESYNC:   st_nxt.rd_data = {5'd0, st_r.resync};
            EFR_ADDR_STATUS:   st_nxt.rd_data = {st_r.clr_evt, cond};
            EFR_ADDR_MASK:     st_nxt.rd_data = st_r.mask;
            EFR_ADDR_SEARCH:   st_nxt.rd_data = {st_r.csc[5:2], st_r.csc[0],
                                  frame_align_search_active, cas_mf_search_active,
                                  crc_mf_search_active};
            default:           st_nxt.rd_data = 8'h00;
         endcase
      end

      // Time-slot-0 bit source selection for the transmitter.
      if (tx_bit_en) begin
         if (tx_is_si_bit) begin
            st_nxt.tx_bit = intl_bit_source_select ? tx_internal_bit
                                                   : serial_tx_data_in;
         end else begin
            st_nxt.tx_bit = slot0_passthrough ? serial_tx_data_in
                                              : tx_internal_bit;
         end
      end
      st_nxt.conflict = intl_bit_source_select & slot0_passthrough;
   end

   // Frame loss is held from reset until sync; histories start idle so no false event follows.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r     <= '0;
         st_r.lof <= 1'b1;
         st_r.cond_prev <= 4'h1; // Frame loss present from reset is no rising edge.
         st_r.sa7_hist  <= 3'h7; // No Sa7 zero has been received yet.
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_r                 = st_r.rd_data;
   assign irq_r                     = st_r.irq;
   assign tx_ts0_bit_r              = st_r.tx_bit;
   assign source_conflict_r         = st_r.conflict;
   assign frame_loss_cond_r         = st_r.lof;
   assign signal_loss_cond_r        = los_line;
   assign all_ones_cond_r           = st_r.ua;
   assign remote_alarm_cond_r       = st_r.ra;
   assign multiframe_remote_alarm_r = st_r.mfra;
   assign v5_link_detect_r          = st_r.v5;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence s_cas_two_bad;
      cas_word_strobe && cas_word_error && st_r.cas_run == 2'd1;
   endsequence

   property p_cas_event;
      s_cas_two_bad |=> st_r.resync[EFR_EVT_CAS] && st_r.lof;
   endproperty
   a_cas_event: assert property (p_cas_event) else $error("cas event missed");

   property p_fas_event;
      fas_word_strobe && fas_word_error && st_r.fas_run == 2'd2
         |=> st_r.resync[EFR_EVT_FAS] && st_r.fas_run == 2'd0;
   endproperty
   a_fas_event: assert property (p_fas_event) else $error("fas event missed");

   property p_lof_manual;
      resync_request |=> frame_loss_cond_r;
   endproperty
   a_lof_manual: assert property (p_lof_manual) else $error("lof not set");

   property p_csc_clear;
      (crc_sync_ok || !crc4_enable) |=> st_r.csc == 6'd0;
   endproperty
   a_csc_clear: assert property (p_csc_clear) else $error("counter not cleared");

   property p_csc_step;
      crc_search_timeout && crc4_enable && !crc_sync_ok
         |=> st_r.csc == $past(st_r.csc) + 6'd1;
   endproperty
   a_csc_step: assert property (p_csc_step) else $error("counter step wrong");

   sequence s_lof_drop;
      $fell(st_r.lof) && !rd_status;
   endsequence

   property p_lof_clear_latch;
      s_lof_drop |=> st_r.clr_evt[0] ##1 (st_r.clr_evt[0] || $past(rd_status));
   endproperty
   a_lof_clear_latch: assert property (p_lof_clear_latch) else $error("no clear event");

   property p_irq_pending;
      irq_r == (|({st_r.clr_evt, st_r.cond_evt} & st_r.mask));
   endproperty
   a_irq_pending: assert property (p_irq_pending) else $error("irq wrong");

   property p_tx_pass;
      tx_bit_en && !tx_is_si_bit && slot0_passthrough |=> tx_ts0_bit_r == $past(serial_tx_data_in);
   endproperty
   a_tx_pass: assert property (p_tx_pass) else $error("passthrough wrong");

   property p_identity;
      rd_en && addr == EFR_ADDR_IDENTITY |=> rd_data_r == {DEVICE_CODE, REVISION};
   endproperty
   a_identity: assert property (p_identity) else $error("identity wrong");

endmodule

// ---- efr_line_model.sv ----
`timescale 1ns/1ps
// Remote line equipment: sends one received bit per clock while run is high.
module efr_line_model (
   input  wire logic clock,
   input  wire logic run,
   input  wire logic level,
   output logic      rx_bit_en,
   output logic      rx_bit
);
   logic go;

   initial begin
      rx_bit_en = 1'b0;
      rx_bit    = 1'b0;
   end

   // Outside a burst the data line toggles, so a stale level is never mistaken for data.
   always @(posedge clock) begin
      go = run;
      #1;
      rx_bit_en = go;
      rx_bit    = go ? level : ~rx_bit;
   end
endmodule

// ---- efr_status_alarms_bench.sv ----
`timescale 1ns/1ps
module efr_status_alarms_bench
   import efr_pkg::*;
;
   localparam logic [3:0] ID_CODE = 4'h5; // Arbitrary value.
   localparam logic [3:0] ID_REV  = 4'h1; // Arbitrary value.
   localparam logic [6:0] SA7_IN   = 7'h67;
   localparam logic [6:0] SA7_LINK = 7'h30;
   logic       clock, rst_b, rd_en, wr_en, run, level, t1, m6312, oor, crit;
   logic       crc_ok, crc_en, act_crc, act_cas, act_fas, yel, is_si, sel, pass;
   logic [7:0] addr, wr_data, rd_data_r, v;
   logic [9:0] stb;
   logic [9:0] dat;
   logic       irq_r, tx_bit, conflict, fl, sl, ao, ra, mra, v5, rx_en, rx_b;
   int         err_count, n_tests, cyc;

   // Line stimulus comes from the partner model so bursts are exact in length.
   efr_line_model i_efr_line_model (.clock(clock), .run(run), .level(level),
      .rx_bit_en(rx_en), .rx_bit(rx_b));

   efr_status_alarms #(.DEVICE_CODE(ID_CODE), .REVISION(ID_REV)) i_efr_status_alarms (
      .clock(clock), .rst_b(rst_b), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
      .wr_data(wr_data), .rd_data_r(rd_data_r), .irq_r(irq_r), .rx_bit_en(rx_en),
      .rx_bit(rx_b), .t1_mode(t1), .sync6312_mode(m6312), .sync6312_out_of_range(oor),
      .signal_loss_criteria_select(crit), .resync_request(stb[8]),
      .frame_sync_achieved(stb[9]), .fas_word_strobe(stb[0]), .fas_word_error(dat[0]),
      .cas_word_strobe(stb[1]), .cas_word_error(dat[1]), .crc_word_strobe(stb[2]),
      .crc_word_error(dat[2]), .crc_search_timeout(stb[3]), .crc_sync_ok(crc_ok),
      .crc4_enable(crc_en), .crc_mf_search_active(act_crc),
      .cas_mf_search_active(act_cas), .frame_align_search_active(act_fas),
      .nfas_strobe(stb[4]), .nfas_bit3(dat[4]), .mf_strobe(stb[5]), .ts16_f0_bit6(dat[5]),
      .sa7_strobe(stb[6]), .sa7_bit(dat[6]), .t1_yellow_detect(yel), .tx_bit_en(stb[7]),
      .tx_is_si_bit(is_si), .tx_internal_bit(1'b1), .serial_tx_data_in(1'b0),
      .intl_bit_source_select(sel), .slot0_passthrough(pass), .tx_ts0_bit_r(tx_bit),
      .source_conflict_r(conflict), .frame_loss_cond_r(fl), .signal_loss_cond_r(sl),
      .all_ones_cond_r(ao), .remote_alarm_cond_r(ra), .multiframe_remote_alarm_r(mra),
      .v5_link_detect_r(v5));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // A hung handshake would otherwise stall the run forever.
   always @(posedge clock) begin
      cyc++;
      if (cyc > 40000) begin
         err_count++;
         results();
      end
   end

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      tick();
      addr  = a;
      rd_en = 1'b1;
      tick();
      rd_en = 1'b0;
      d     = rd_data_r;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(d, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick();
      addr    = a;
      wr_data = d;
      wr_en   = 1'b1;
      tick();
      wr_en = 1'b0;
   endtask

   // One-cycle strobe with its data bit; the outputs are looked at two edges later.
   task automatic pulse(input int i, input logic d);
      tick();
      stb[i] = 1'b1;
      dat[i] = d;
      tick();
      stb[i] = 1'b0;
      tick(2);
   endtask

   task automatic line(input logic lv, input int n);
      run   = 1'b1;
      level = lv;
      tick(n);
      run = 1'b0;
      tick(3);
   endtask

   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      {rst_b, rd_en, wr_en, run, level, t1, m6312, oor, crit} = '0;
      {crc_ok, crc_en, act_crc, act_cas, act_fas, yel, is_si, sel, pass} = '0;
      {addr, wr_data, stb, dat} = '0;
      err_count = 0;
      n_tests   = 0;
      cyc       = 0;
      repeat (6) @(posedge clock);
      #1 rst_b = 1'b1;
      // Reset values, a write to a read-only place and an unmapped read.
      wr(EFR_ADDR_IDENTITY, 8'hff);
      rdc(EFR_ADDR_IDENTITY, {ID_CODE, ID_REV});
      rdc(EFR_ADDR_RESYNC, 8'h00);
      rdc(EFR_ADDR_STATUS, 8'h01);
      rdc(EFR_ADDR_MASK, 8'h00);
      rdc(EFR_ADDR_SEARCH, 8'h00);
      rdc(8'h20, 8'h00);
      wr(EFR_ADDR_MASK, 8'h11);
      rdc(EFR_ADDR_MASK, 8'h11);
      chk(irq_r, 1'b0);
      pulse(9, 1'b0);
      chk(fl, 1'b0);
      chk(irq_r, 1'b1);
      rdc(EFR_ADDR_STATUS, 8'h10);
      chk(irq_r, 1'b0);
      rdc(EFR_ADDR_STATUS, 8'h00);
      // Manual resync raises frame loss and its rising-edge interrupt once.
      pulse(8, 1'b0);
      chk(fl, 1'b1);
      chk(irq_r, 1'b1);
      rdc(EFR_ADDR_STATUS, 8'h01);
      chk(irq_r, 1'b0);
      pulse(9, 1'b0);
      rdc(EFR_ADDR_STATUS, 8'h10);
      // A good word in the middle breaks the run of errors.
      foreach (v[i]) if (i < 5) pulse(0, i != 2);
      rdc(EFR_ADDR_RESYNC, 8'h00);
      pulse(0, 1'b1);
      rdc(EFR_ADDR_RESYNC, 8'h02);
      chk(fl, 1'b1);
      rdc(EFR_ADDR_RESYNC, 8'h00);
      pulse(1, 1'b1);
      pulse(1, 1'b0);
      pulse(1, 1'b1);
      rdc(EFR_ADDR_RESYNC, 8'h00);
      pulse(1, 1'b1);
      rdc(EFR_ADDR_RESYNC, 8'h01);
      // One block just under the error limit, then one exactly at it.
      for (int i = 0; i < 1000; i++) pulse(2, i < 914);
      rdc(EFR_ADDR_RESYNC, 8'h00);
      for (int i = 0; i < 1000; i++) pulse(2, i < 915);
      rdc(EFR_ADDR_RESYNC, 8'h04);
      // Sync counter walks through its wrap with bit 1 hidden.
      {act_crc, act_fas, crc_en} = 3'b111;
      for (int k = 1; k <= 67; k++) begin
         pulse(3, 1'b0);
         v = 8'(k % 64);
         rdc(EFR_ADDR_SEARCH, {v[5:2], v[0], 3'b101});
      end
      crc_ok = 1'b1;
      tick(2);
      rdc(EFR_ADDR_SEARCH, 8'h05);
      crc_ok = 1'b0;
      pulse(3, 1'b0);
      rdc(EFR_ADDR_SEARCH, 8'h0d);
      crc_en  = 1'b0;
      act_cas = 1'b1;
      tick(2);
      rdc(EFR_ADDR_SEARCH, 8'h07);
      {act_crc, act_cas, act_fas} = 3'b000;
      rdc(EFR_ADDR_SEARCH, 8'h00);
      // Signal loss thresholds for both E1 criteria and T1, one bit short first.
      line(1'b0, 254);
      chk(sl, 1'b0);
      line(1'b0, 1);
      chk(sl, 1'b1);
      line(1'b1, 1100);
      chk(sl, 1'b0);
      chk(ao, 1'b1);
      rd(EFR_ADDR_STATUS, v);
      chk({v[5], v[2]}, 2'b11);
      crit = 1'b1;
      line(1'b0, 2047);
      chk({sl, ao}, 2'b00);
      line(1'b0, 1);
      chk(sl, 1'b1);
      line(1'b1, 600);
      t1 = 1'b1;
      line(1'b0, 191);
      chk(sl, 1'b0);
      line(1'b0, 1);
      chk(sl, 1'b1);
      line(1'b1, 300);
      chk(sl, 1'b0);
      {m6312, oor} = 2'b11;
      tick(3);
      rd(EFR_ADDR_STATUS, v);
      chk(v[1], 1'b1);
      {m6312, oor, t1} = 3'b000;
      // Yellow is reported in T1 mode only.
      yel = 1'b1;
      tick(3);
      rd(EFR_ADDR_STATUS, v);
      chk(v[3], 1'b0);
      t1 = 1'b1;
      tick(3);
      rd(EFR_ADDR_STATUS, v);
      chk(v[3], 1'b1);
      yel = 1'b0;
      tick(3);
      rd(EFR_ADDR_STATUS, v);
      chk({v[7], v[3]}, 2'b10);
      t1 = 1'b0;
      // Remote alarm needs three equal values in a row each way.
      pulse(4, 1'b1);
      pulse(4, 1'b1);
      chk(ra, 1'b0);
      pulse(4, 1'b1);
      chk(ra, 1'b1);
      pulse(4, 1'b0);
      pulse(4, 1'b0);
      chk(ra, 1'b1);
      pulse(4, 1'b0);
      chk(ra, 1'b0);
      pulse(5, 1'b1);
      chk(mra, 1'b0);
      pulse(5, 1'b1);
      chk(mra, 1'b1);
      // Sa7 history 1,1,1,0,0,1,1 gives the link flag 0,0,0,0,1,1,0.
      for (int i = 0; i < 7; i++) begin
         pulse(6, SA7_IN[i]);
         chk(v5, SA7_LINK[i]);
      end
      // Every source-select setting for Si and non-Si bits.
      for (int s = 0; s < 8; s++) begin
         {sel, pass, is_si} = 3'(s);
         pulse(7, 1'b0);
         if (!(sel && pass))
            chk(tx_bit, is_si ? sel : !pass);
         chk(conflict, sel && pass);
      end
      results();
   end
endmodule
